// ===== rtl/flash_status_config_pkg.sv
package flash_status_config_pkg;

   // timing of the register writes
   localparam int CLOCK_PERIOD_NS   = 100;
   localparam int NV_WRITE_TIME_NS  = 200000;
   localparam int VOL_WRITE_TIME_NS = 50;
   localparam int NV_WRITE_RAW      = (NV_WRITE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int VOL_WRITE_RAW     = (VOL_WRITE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int NV_WRITE_CYCLES   = (NV_WRITE_RAW < 1) ? 1 : NV_WRITE_RAW;
   localparam int VOL_WRITE_CYCLES  = (VOL_WRITE_RAW < 1) ? 1 : VOL_WRITE_RAW;

   // command codes
   localparam logic [7:0] CMD_READ_SECOND_STATUS = 8'h07;
   localparam logic [7:0] CMD_READ_ANY_REGISTER  = 8'h65;
   localparam logic [7:0] CMD_WRITE_REGISTERS    = 8'h01;
   localparam logic [7:0] CMD_WRITE_ANY_REGISTER = 8'h71;

   // register addresses for the any-register commands
   localparam logic [23:0] ADDR_SUSPEND_ERASE_STATUS  = 24'h000001;
   localparam logic [23:0] ADDR_NONVOLATILE_CONFIG    = 24'h000002;

   // field positions and reset values
   localparam int         BP_LSB          = 2;
   localparam int         BP_MSB          = 4;
   localparam logic [7:0] SR2_RESET       = 8'h00;
   localparam logic [7:0] CFG_SHIPPED     = 8'h00;
   localparam logic [2:0] NV_PROTECT_SHIPPED = 3'h0;
   localparam logic [2:0] BP_ALL          = 3'h7;
   localparam logic [4:0] SR2_RESERVED    = 5'h00;

   typedef enum logic [2:0] {
      PH_COMMAND    = 3'b000,
      PH_ADDRESS    = 3'b001,
      PH_WRITE_DATA = 3'b010,
      PH_READ       = 3'b011,
      PH_IGNORE     = 3'b100
   } phase_t;

   typedef struct packed {
      logic sck;
      logic csN;
      logic si;
   } spi_in_t;

   typedef struct packed {
      logic [1:0] reservedHigh;
      logic       protectStartSelect;
      logic       reservedMid;
      logic       protectVolatilitySelect;
      logic       parameterSectorLocation;
      logic       quadWidthDefault;
      logic       freezeDefault;
   } nvcfg_t;

   typedef struct packed {
      spi_in_t     pinMeta;
      spi_in_t     pinSync;
      spi_in_t     pinDly;
      phase_t      phase;
      logic [2:0]  bitCnt;
      logic [2:0]  outCnt;
      logic [1:0]  byteCnt;
      logic [7:0]  cmd;
      logic [7:0]  shiftIn;
      logic [7:0]  shiftOut;
      logic [23:0] addr;
      logic [7:0]  wrByte0;
      logic [7:0]  wrByte1;
      logic        soBit;
      logic        soEn;
      logic        eraseSuspendedFlag;
      logic        programSuspendedFlag;
      logic        eraseResultBit;
      nvcfg_t      cfg;
      nvcfg_t      pendCfg;
      logic [2:0]  bpNv;
      logic [2:0]  bpVol;
      logic [2:0]  pendBpNv;
      logic [2:0]  pendBpVol;
      logic [15:0] busyCnt;
      logic        accessRejected;
   } state_t;

endpackage

// ===== rtl/flash_protect_range.sv
`timescale 1ns/1ns
module flash_protect_range
   import flash_status_config_pkg::*;
#(
   parameter int ADDR_WIDTH = 23
) (
   input  wire logic                  clock,
   input  wire logic                  sys_rst,
   input  wire logic [2:0]            protectRangeBits,
   input  wire logic                  fromBottom,
   input  wire logic [ADDR_WIDTH-1:0] addr,
   output logic                       hit
);

   generate
      if (ADDR_WIDTH < 6) begin : g_bad_width
         $error("address width too small for 1/64 protection steps");
      end
   endgenerate

   // range doubles per step: value 1 covers 1/64, 6 covers 1/2, 7 the whole array
   always_comb begin
      hit = 1'b0;
      if (protectRangeBits == BP_ALL) begin
         hit = 1'b1;
      end else if (protectRangeBits != 3'h0) begin
         hit = 1'b1;
         for (int i = 0; i < 6; i++) begin
            if (i < 32'(3'h7 - protectRangeBits)) begin
               // top anchor needs upper ones, bottom anchor upper zeros
               hit = hit & (addr[ADDR_WIDTH-1-i] == ~fromBottom);
            end
         end
      end
   end

   a_whole_array: assert property (@(posedge clock) disable iff (sys_rst)
      (protectRangeBits == 3'h7) |-> hit)
      else $error("whole array not protected");

   a_none_open: assert property (@(posedge clock) disable iff (sys_rst)
      (protectRangeBits == 3'h0) |-> !hit)
      else $error("protection hit with range bits clear");

endmodule

// ===== rtl/flash_status_config_regs.sv
`timescale 1ns/1ns
// Overview of operation
// - second status register is read-only hardware status; reserved and defined bits reset zero.
// - second status register reads by its own command and by read-any-register.
// - bit 2 captures last erase-status query result: one completed, zero not.
// - during program or erase suspend the erase result bit may be invalid.
// - bit 1 is one exactly while erase suspended; writes cannot change it.
// - bit 0 is one exactly while program suspended; writes cannot change it.
// - configuration written by write-registers second byte or by write-any-register.
// - config bit 5 zero protects from top, one protects from address zero.
// - protection range steps from 1/64 of array to whole array.
// - one-time config bits once one stay one; writing zero raises no error.
// - config bit 3 zero: write-registers programs nonvolatile protect bits, slow write.
// - setting bit 3 programs nonvolatile protect bits to 111, loaded on command reset.
// - bit 3 one: write-registers updates volatile protect bits only, fast write when no config byte follows.
// - config bit 2 puts parameter sectors top when one, bottom when zero.
// - config bit 1 is writable nonvolatile quad default, zero by default.
// - config bit 0 is read-only freeze default, zero by default.
// - shipped with bit 3 zero, protect bits 000, reserved bits zero.
// - any active protect bit set rejects program or erase in the range.
// - while freeze is set protect and one-time bits ignore writes silently.
module flash_status_config_regs
   import flash_status_config_pkg::*;
#(
   parameter int ADDR_WIDTH      = 23,
   parameter int NV_WRITE_COUNT  = NV_WRITE_CYCLES,
   parameter int VOL_WRITE_COUNT = VOL_WRITE_CYCLES
) (
   input  wire logic                  clock,
   input  wire logic                  sys_rst,
   input  wire logic                  clkEn,
   input  wire spi_in_t               spiIn,
   output logic                       soData,
   output logic                       soEn,
   input  wire logic                  writeEnable,
   input  wire logic                  freezeActive,
   input  wire logic                  softReset,
   input  wire logic                  eraseSuspended,
   input  wire logic                  programSuspended,
   input  wire logic                  eraseQueryDone,
   input  wire logic                  eraseQueryResult,
   input  wire logic                  checkReq,
   input  wire logic [ADDR_WIDTH-1:0] checkAddr,
   output logic                       accessRejected,
   output logic                       busy,
   output logic [2:0]                 activeProtect,
   output nvcfg_t                     cfgOut
);

   generate
      if (NV_WRITE_COUNT < 1 || NV_WRITE_COUNT > 65535 || VOL_WRITE_COUNT < 1 || VOL_WRITE_COUNT > 65535) begin : g_bad
         $error("write time counts must fit 1..65535 cycles");
      end
   endgenerate

   state_t      st;
   state_t      next_st;
   logic        sckRise;
   logic        sckFall;
   logic        selected;
   logic        frameEnd;
   logic        rangeHit;
   logic        writeStart;
   logic [7:0]  byteIn;
   logic [7:0]  sr2Value;
   logic [7:0]  readValue;
   logic [23:0] readAddr;

   // merge a written byte into the config: one-time bits only set, freeze locks them
   function automatic nvcfg_t mergeCfg(input nvcfg_t old, input logic [7:0] data, input logic frozen);
      nvcfg_t n;
      n = old;
      n.reservedHigh = 2'h0;
      n.reservedMid = 1'b0;
      n.quadWidthDefault = data[1];
      if (!frozen) begin
         n.protectStartSelect = old.protectStartSelect | data[5];
         n.protectVolatilitySelect = old.protectVolatilitySelect | data[3];
         n.parameterSectorLocation = old.parameterSectorLocation | data[2];
      end
      return n;
   endfunction

   // register value seen by the read commands
   function automatic logic [7:0] regValue(input logic [23:0] a, input logic [7:0] sr2, input nvcfg_t c);
      logic [7:0] v;
      v = 8'h00;
      if (a == ADDR_SUSPEND_ERASE_STATUS) begin
         v = sr2;
      end else if (a == ADDR_NONVOLATILE_CONFIG) begin
         v = c;
      end
      return v;
   endfunction

   // pin edges from the synchronised copies
   assign sckRise  = st.pinSync.sck & ~st.pinDly.sck;
   assign sckFall  = ~st.pinSync.sck & st.pinDly.sck;
   assign selected = ~st.pinSync.csN;
   assign frameEnd = st.pinSync.csN & ~st.pinDly.csN;
   assign byteIn   = {st.shiftIn[6:0], st.pinSync.si};
   assign sr2Value = {SR2_RESERVED, st.eraseResultBit, st.eraseSuspendedFlag, st.programSuspendedFlag};
   assign readAddr = (st.cmd == CMD_READ_SECOND_STATUS) ? ADDR_SUSPEND_ERASE_STATUS : st.addr;
   assign readValue = regValue(readAddr, sr2Value, st.cfg);

   // a completed write frame, whole bytes only, latch enabled, not busy
   assign writeStart = frameEnd & writeEnable & (st.busyCnt == 16'h0000) & (st.phase == PH_WRITE_DATA)
                       & (st.bitCnt == 3'h0) & (st.byteCnt != 2'h0)
                       & ((st.cmd == CMD_WRITE_REGISTERS)
                          | ((st.cmd == CMD_WRITE_ANY_REGISTER) & (st.addr == ADDR_NONVOLATILE_CONFIG)));

   // active protection follows the volatility select
   assign activeProtect  = st.cfg.protectVolatilitySelect ? st.bpVol : st.bpNv;
   assign cfgOut         = st.cfg;
   assign soData         = st.soBit;
   assign soEn           = st.soEn;
   assign busy           = (st.busyCnt != 16'h0000);
   assign accessRejected = st.accessRejected;

   flash_protect_range #(
      .ADDR_WIDTH (ADDR_WIDTH)
   ) u_range (
      .clock            (clock),
      .sys_rst          (sys_rst),
      .protectRangeBits (activeProtect),
      .fromBottom       (st.cfg.protectStartSelect),
      .addr             (checkAddr),
      .hit              (rangeHit)
   );

   // next state of the whole block
   always_comb begin
      nvcfg_t     newCfg;
      logic [2:0] newBpNv;
      logic [2:0] newBpVol;
      logic       nvTouched;
      logic       cfgByte;
      newCfg    = st.cfg;
      newBpNv   = st.bpNv;
      newBpVol  = st.bpVol;
      nvTouched = 1'b0;
      cfgByte   = (st.cmd == CMD_WRITE_ANY_REGISTER) | (st.byteCnt == 2'h2);
      next_st   = st;

      next_st.pinMeta = spiIn;
      next_st.pinSync = st.pinMeta;
      next_st.pinDly  = st.pinSync;

      // hardware status, never touched by writes; erase result not qualified by suspend
      next_st.eraseSuspendedFlag   = eraseSuspended;
      next_st.programSuspendedFlag = programSuspended;
      if (eraseQueryDone) begin
         next_st.eraseResultBit = eraseQueryResult;
      end

      next_st.accessRejected = checkReq & rangeHit;

      // serial frame decode
      if (!selected) begin
         next_st.phase   = PH_COMMAND;
         next_st.bitCnt  = 3'h0;
         next_st.byteCnt = 2'h0;
         next_st.soEn    = 1'b0;
      end else begin
         if (sckRise) begin
            next_st.shiftIn = byteIn;
            next_st.bitCnt  = st.bitCnt + 3'h1;
            if (st.bitCnt == 3'h7) begin
               case (st.phase)
                  PH_COMMAND: begin
                     next_st.cmd     = byteIn;
                     next_st.byteCnt = 2'h0;
                     next_st.outCnt  = 3'h0;
                     case (byteIn)
                        CMD_READ_SECOND_STATUS: next_st.phase = PH_READ;
                        CMD_READ_ANY_REGISTER:  next_st.phase = PH_ADDRESS;
                        CMD_WRITE_REGISTERS:    next_st.phase = busy ? PH_IGNORE : PH_WRITE_DATA;
                        CMD_WRITE_ANY_REGISTER: next_st.phase = busy ? PH_IGNORE : PH_ADDRESS;
                        default:                next_st.phase = PH_IGNORE;
                     endcase
                  end
                  PH_ADDRESS: begin
                     next_st.addr    = {st.addr[15:0], byteIn};
                     next_st.byteCnt = st.byteCnt + 2'h1;
                     if (st.byteCnt == 2'h2) begin
                        next_st.byteCnt = 2'h0;
                        next_st.outCnt  = 3'h0;
                        next_st.phase   = (st.cmd == CMD_READ_ANY_REGISTER) ? PH_READ : PH_WRITE_DATA;
                     end
                  end
                  PH_WRITE_DATA: begin
                     if (st.byteCnt == 2'h0) begin
                        next_st.wrByte0 = byteIn;
                     end else if (st.byteCnt == 2'h1) begin
                        next_st.wrByte1 = byteIn;
                     end
                     if (st.byteCnt != 2'h2) begin
                        next_st.byteCnt = st.byteCnt + 2'h1;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         // read data changes on the falling edge, value reloaded every eight bits
         if (sckFall && st.phase == PH_READ) begin
            next_st.soEn   = 1'b1;
            next_st.outCnt = st.outCnt + 3'h1;
            if (st.outCnt == 3'h0) begin
               next_st.soBit    = readValue[7];
               next_st.shiftOut = {readValue[6:0], 1'b0};
            end else begin
               next_st.soBit    = st.shiftOut[7];
               next_st.shiftOut = {st.shiftOut[6:0], 1'b0};
            end
         end
      end

      // work out a write at the end of its frame
      if (st.cmd == CMD_WRITE_ANY_REGISTER) begin
         newCfg = mergeCfg(st.cfg, st.wrByte0, freezeActive);
         nvTouched = 1'b1;
      end else if (cfgByte) begin
         newCfg = mergeCfg(st.cfg, st.wrByte1, freezeActive);
         nvTouched = 1'b1;
      end
      if (st.cmd == CMD_WRITE_REGISTERS && !freezeActive) begin
         if (st.cfg.protectVolatilitySelect) begin
            newBpVol = st.wrByte0[BP_MSB:BP_LSB];
         end else begin
            newBpNv   = st.wrByte0[BP_MSB:BP_LSB];
            newBpVol  = st.wrByte0[BP_MSB:BP_LSB];
            nvTouched = 1'b1;
         end
      end
      if (newCfg.protectVolatilitySelect && !st.cfg.protectVolatilitySelect) begin
         newBpNv   = BP_ALL;
         nvTouched = 1'b1;
      end

      // hold the result until the write time runs out
      if (writeStart) begin
         next_st.pendCfg   = newCfg;
         next_st.pendBpNv  = newBpNv;
         next_st.pendBpVol = newBpVol;
         next_st.busyCnt   = nvTouched ? 16'(NV_WRITE_COUNT) : 16'(VOL_WRITE_COUNT);
      end else if (st.busyCnt != 16'h0000) begin
         next_st.busyCnt = st.busyCnt - 16'h0001;
         if (st.busyCnt == 16'h0001) begin
            next_st.cfg   = st.pendCfg;
            next_st.bpNv  = st.pendBpNv;
            next_st.bpVol = st.pendBpVol;
         end
      end

      // command reset reloads volatile protection from the nonvolatile copy
      if (softReset) begin
         next_st.bpVol   = st.bpNv;
         next_st.busyCnt = 16'h0000;
         next_st.phase   = PH_IGNORE;
      end
   end

   // state register; reset restores shipped state
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st           <= '0;
         st.pinMeta   <= 3'b010;
         st.pinSync   <= 3'b010;
         st.pinDly    <= 3'b010;
         st.phase     <= PH_COMMAND;
         st.cfg       <= CFG_SHIPPED;
         st.pendCfg   <= CFG_SHIPPED;
         st.bpNv      <= NV_PROTECT_SHIPPED;
         st.bpVol     <= NV_PROTECT_SHIPPED;
         st.pendBpNv  <= NV_PROTECT_SHIPPED;
         st.pendBpVol <= NV_PROTECT_SHIPPED;
      end else if (clkEn) begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence s_write_nv;
      clkEn && writeStart && !st.cfg.protectVolatilitySelect && !softReset;
   endsequence

   sequence s_write_vol_bp;
      clkEn && writeStart && st.cfg.protectVolatilitySelect && st.cmd == CMD_WRITE_REGISTERS
      && st.byteCnt == 2'h1 && !softReset;
   endsequence

   a_sr2_reserved: assert property (readAddr == ADDR_SUSPEND_ERASE_STATUS |-> readValue[7:3] == 5'h00)
      else $error("reserved status bits not zero");

   a_reset_state: assert property ($past(sys_rst) |-> sr2Value == SR2_RESET && st.cfg == CFG_SHIPPED
                                                      && st.bpNv == NV_PROTECT_SHIPPED)
      else $error("reset state wrong");

   a_erase_suspend: assert property (clkEn |=> st.eraseSuspendedFlag == $past(eraseSuspended))
      else $error("erase suspend flag does not track");

   a_program_suspend: assert property (clkEn |=> st.programSuspendedFlag == $past(programSuspended))
      else $error("program suspend flag does not track");

   a_result_capture: assert property (clkEn && eraseQueryDone |=> st.eraseResultBit == $past(eraseQueryResult))
      else $error("erase result not captured");

   a_otp_sticky: assert property (clkEn |=> (8'($past(st.cfg)) & ~8'(st.cfg) & 8'h2c) == 8'h00)
      else $error("one-time bit cleared");

   a_nv_write_time: assert property (s_write_nv |=> st.busyCnt == 16'(NV_WRITE_COUNT))
      else $error("nonvolatile write time wrong");

   a_vol_write_fast: assert property (s_write_vol_bp ##1 !freezeActive [*1] |->
                                      st.busyCnt == 16'(VOL_WRITE_COUNT) && st.pendBpNv == st.bpNv)
      else $error("volatile protect write wrong");

   a_bpnv_all_ones: assert property ($rose(st.cfg.protectVolatilitySelect) |-> st.bpNv == BP_ALL)
      else $error("nonvolatile protect bits not 111");

   a_freeze_locks: assert property (clkEn && writeStart && freezeActive |=>
                                    st.pendBpNv == $past(st.bpNv) && st.pendBpVol == $past(st.bpVol))
      else $error("protect bits changed under freeze");

   a_reject_range: assert property (clkEn && checkReq && rangeHit |=> accessRejected)
      else $error("protected access not rejected");

   a_read_msb: assert property (clkEn && selected && sckFall && st.phase == PH_READ && st.outCnt == 3'h0
                                |=> soData == $past(readValue[7]))
      else $error("read does not start with msb");

endmodule

// ===== testbench/spi_host_model.sv
`timescale 1ns/1ns
module spi_host_model
   import flash_status_config_pkg::*;
(
   input  wire logic clock,
   input  wire logic soData,
   input  wire logic soEn,
   output spi_in_t   spiPins
);
   localparam int HALF = 5; // clocks per sck high half, low half twice that; above the sync budget
   // sck idles low, frame deselected
   initial begin
      spiPins = 3'b010;
   end
   // one mode 0 frame, msb first; gives the last two bytes read and soEn
   task automatic frame(input logic [7:0] tx [6], input int n, output logic [7:0] rxA,
                        output logic [7:0] rxB, output logic en);
      logic [7:0] rx;
      rx = 8'h00;
      rxA = 8'h00;
      rxB = 8'h00;
      @(negedge clock);
      spiPins.csN = 1'b0;
      repeat (HALF) @(negedge clock);
      for (int k = 0; k < n; k++) begin
         for (int b = 7; b >= 0; b--) begin
            rx = {rx[6:0], soData};
            spiPins.si = tx[k][b];
            repeat (HALF) @(negedge clock);
            spiPins.sck = 1'b1;
            repeat (HALF) @(negedge clock);
            spiPins.sck = 1'b0;
            repeat (HALF) @(negedge clock);
         end
         rxA = rxB;
         rxB = rx;
      end
      en = soEn;
      spiPins.csN = 1'b1;
      spiPins.si = ~spiPins.si; // released line does not keep its level
      repeat (HALF + 2) @(negedge clock);
   endtask
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import flash_status_config_pkg::*;
   localparam int NVC = 5;
   typedef struct {logic eraseSusp; logic progSusp; logic res; logic viaAny; logic [7:0] expVal;} row_t;
   logic       clock, sys_rst, writeEnable, freezeActive, softReset, eraseSuspended;
   logic       programSuspended, eraseQueryDone, eraseQueryResult, checkReq, soData, soEn;
   logic       accessRejected, busy, rdEn;
   logic [22:0] checkAddr;
   logic [2:0] activeProtect;
   logic [7:0] rxA, rxB;
   nvcfg_t     cfgOut;
   spi_in_t    spiPins;
   int         miscompares = 0;
   int         cmp_count = 0;
   int         busyCnt = 0;
   row_t rows [5] = '{'{1,0,1,0,8'h06}, '{0,1,0,1,8'h01}, '{1,1,1,1,8'h07}, '{0,0,0,0,8'h00},
                      '{0,1,1,1,8'h05}};
   flash_status_config_regs #(.ADDR_WIDTH(23), .NV_WRITE_COUNT(NVC), .VOL_WRITE_COUNT(1))
   u_flash_status_config_regs (.clock(clock), .sys_rst(sys_rst), .clkEn(1'b1), .spiIn(spiPins),
      .soData(soData), .soEn(soEn), .writeEnable(writeEnable), .freezeActive(freezeActive),
      .softReset(softReset), .eraseSuspended(eraseSuspended), .programSuspended(programSuspended),
      .eraseQueryDone(eraseQueryDone), .eraseQueryResult(eraseQueryResult), .checkReq(checkReq),
      .checkAddr(checkAddr), .accessRejected(accessRejected), .busy(busy),
      .activeProtect(activeProtect), .cfgOut(cfgOut));
   spi_host_model u_spi_host_model (.clock(clock), .soData(soData), .soEn(soEn), .spiPins(spiPins));
   // 100 ns clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // counts write time cycles, sampled away from the launching edge
   always @(negedge clock) begin
      if (busy === 1'b1) begin
         busyCnt++;
      end
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expVal);
      cmp_count++;
      if (seen !== expVal) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, expVal, seen);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // write frame, then bounded wait for the commit
   task automatic wr(input logic [7:0] tx [6], input int n);
      int w;
      w = 0;
      busyCnt = 0;
      u_spi_host_model.frame(tx, n, rxA, rxB, rdEn);
      while (busy === 1'b1 && w < 100) begin
         @(negedge clock);
         w++;
      end
      if (w == 100) begin
         check("busy timeout", 8'h01, 8'h00);
         stop_test();
      end
      @(negedge clock);
   endtask
   // read frame holding the value for two bytes
   task automatic rd(input logic viaAny, input logic [23:0] a);
      if (viaAny) begin
         u_spi_host_model.frame('{CMD_READ_ANY_REGISTER, a[23:16], a[15:8], a[7:0], 8'h00, 8'h00}, 6,
                                rxA, rxB, rdEn);
      end else begin
         u_spi_host_model.frame('{CMD_READ_SECOND_STATUS, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 3,
                                rxA, rxB, rdEn);
      end
      check("repeat", rxB, rxA);
      check("soEn", {7'h00, rdEn}, 8'h01);
   endtask
   // address check, answer within two cycles
   task automatic probe(input logic [22:0] a, input logic expVal);
      logic seen;
      checkAddr = a;
      checkReq = 1'b1;
      @(negedge clock);
      checkReq = 1'b0;
      seen = accessRejected;
      @(negedge clock);
      seen = seen | accessRejected;
      check("reject", {7'h00, seen}, {7'h00, expVal});
   endtask
   task automatic srst();
      softReset = 1'b1;
      @(negedge clock);
      softReset = 1'b0;
      repeat (2) @(negedge clock);
   endtask
   initial begin
      sys_rst = 1'b1;
      writeEnable = 1'b1;
      freezeActive = 1'b0;
      softReset = 1'b0;
      eraseSuspended = 1'b0;
      programSuspended = 1'b0;
      eraseQueryDone = 1'b0;
      eraseQueryResult = 1'b0;
      checkReq = 1'b0;
      checkAddr = '0;
      repeat (2) @(negedge clock);
      sys_rst = 1'b0;
      check("cfg", cfgOut, 8'h00);
      check("prot", {5'h00, activeProtect}, 8'h00);
      repeat (4) @(negedge clock);
      probe(23'h7fffff, 1'b0);
      rd(1'b0, 24'h0);
      check("sr2", rxB, 8'h00);
      for (int i = 0; i < 5; i++) begin
         eraseSuspended = rows[i].eraseSusp;
         programSuspended = rows[i].progSusp;
         eraseQueryResult = rows[i].res;
         eraseQueryDone = 1'b1;
         @(negedge clock);
         eraseQueryDone = 1'b0;
         rd(rows[i].viaAny, ADDR_SUSPEND_ERASE_STATUS);
         check("sr2", rxB, rows[i].expVal);
      end
      wr('{CMD_WRITE_ANY_REGISTER, 8'h00, 8'h00, 8'h01, 8'hff, 8'h00}, 5);
      rd(1'b0, 24'h0);
      check("sr2 wr", rxB, 8'h05);
      rd(1'b1, 24'h000005);
      check("unmapped", rxB, 8'h00);
      $display("test status done");
      wr('{CMD_WRITE_REGISTERS, 8'h08, 8'h02, 8'h00, 8'h00, 8'h00}, 3);
      check("nv time", 8'(busyCnt), 8'(NVC));
      check("cfg", cfgOut, 8'h02);
      check("prot", {5'h00, activeProtect}, 8'h02);
      probe(23'h7c0000, 1'b1);
      probe(23'h7bffff, 1'b0);
      rd(1'b1, ADDR_NONVOLATILE_CONFIG);
      check("cfg rd", rxB, 8'h02);
      // start anchor chosen before any array program or erase; probes so far only ask
      wr('{CMD_WRITE_ANY_REGISTER, 8'h00, 8'h00, 8'h02, 8'h21, 8'h00}, 5);
      check("cfg", cfgOut, 8'h20);
      probe(23'h03ffff, 1'b1);
      probe(23'h040000, 1'b0);
      $display("test protect done");
      wr('{CMD_WRITE_REGISTERS, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00}, 3);
      check("otp", cfgOut, 8'h20);
      check("prot", {5'h00, activeProtect}, 8'h01);
      freezeActive = 1'b1;
      wr('{CMD_WRITE_ANY_REGISTER, 8'h00, 8'h00, 8'h02, 8'h0e, 8'h00}, 5);
      check("frz cfg", cfgOut, 8'h22);
      wr('{CMD_WRITE_REGISTERS, 8'h1c, 8'h22, 8'h00, 8'h00, 8'h00}, 3);
      check("frz prot", {5'h00, activeProtect}, 8'h01);
      freezeActive = 1'b0;
      $display("test freeze done");
      // write latch low: the whole frame is dropped
      writeEnable = 1'b0;
      wr('{CMD_WRITE_REGISTERS, 8'h1c, 8'h00, 8'h00, 8'h00, 8'h00}, 3);
      check("we low cfg", cfgOut, 8'h22);
      check("we low prot", {5'h00, activeProtect}, 8'h01);
      writeEnable = 1'b1;
      $display("test write latch done");
      wr('{CMD_WRITE_REGISTERS, 8'h04, 8'h28, 8'h00, 8'h00, 8'h00}, 3);
      check("cfg", cfgOut, 8'h28);
      check("prot", {5'h00, activeProtect}, 8'h01);
      srst();
      check("prot", {5'h00, activeProtect}, 8'h07);
      // status byte only: a config byte would be a nonvolatile write
      wr('{CMD_WRITE_REGISTERS, 8'h0c, 8'h20, 8'h00, 8'h00, 8'h00}, 2);
      check("vol time", 8'(busyCnt), 8'h01);
      check("cfg", cfgOut, 8'h28);
      check("prot", {5'h00, activeProtect}, 8'h03);
      srst();
      check("prot", {5'h00, activeProtect}, 8'h07);
      $display("test volatile done");
      sys_rst = 1'b1;
      repeat (2) @(negedge clock);
      sys_rst = 1'b0;
      @(negedge clock);
      check("cfg", cfgOut, 8'h00);
      check("prot", {5'h00, activeProtect}, 8'h00);
      $display("test reset done");
      stop_test();
   end
endmodule
